// ==== hw/ipd_pkg.sv ====
// ipd_pkg: constants for the input reference prescale divider
// assumes a 25 MHz system clock and byte-wide registers on a word bus
package ipd_pkg;
  // ****************************************************************
  // register map (printed offsets are indices, byte address = 4x)
  // ****************************************************************
  localparam logic [7:0]  IPD_IDX_DIV_LOW   = 8'h46;
  localparam logic [7:0]  IPD_IDX_DIV_HIGH  = 8'h47;
  localparam logic [7:0]  IPD_IDX_PATH_SEL  = 8'h50;
  localparam logic [7:0]  IPD_IDX_STATUS    = 8'h51;
  localparam logic [9:0]  IPD_ADDR_DIV_LOW  = {IPD_IDX_DIV_LOW, 2'b00};
  localparam logic [9:0]  IPD_ADDR_DIV_HIGH = {IPD_IDX_DIV_HIGH, 2'b00};
  localparam logic [9:0]  IPD_ADDR_PATH_SEL = {IPD_IDX_PATH_SEL, 2'b00};
  localparam logic [9:0]  IPD_ADDR_STATUS   = {IPD_IDX_STATUS, 2'b00};
  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          IPD_DIV_W         = 14;
  localparam int          IPD_HIGH_W        = 6;
  localparam logic [7:0]  IPD_DIV_LOW_RST   = 8'hFF;
  localparam logic [7:0]  IPD_DIV_HIGH_RST  = 8'h3F;
  localparam logic [13:0] IPD_DIV_MAX       = 14'h30D3;
  localparam logic [31:0] IPD_UNMAPPED_RD   = 32'h0000_0000;
  localparam int          IPD_SYNC_STAGES   = 3;
endpackage

// ==== hw/ipd_edge_sync.sv ====
// ipd_edge_sync: three-stage synchroniser with rising edge pulse
// assumes the input is asynchronous to sys_clk
`timescale 1ns/1ps
module ipd_edge_sync
  import ipd_pkg::*;
(
  input  wire logic sys_clk,   // system clock
  input  wire logic rstn,      // async reset, active low
  input  wire logic pin_in,    // raw asynchronous level
  output logic      level_out, // settled level
  output logic      rise_out   // one-cycle pulse on a settled rise
);
  typedef struct packed {
    logic [IPD_SYNC_STAGES-1:0] sh;
    logic                       lvl;
  } ipd_sync_t;
  ipd_sync_t s_q, s_d;

  // a change counts once stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[IPD_SYNC_STAGES-2:0], pin_in};
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.lvl = s_q.sh[2];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.lvl;
  assign rise_out  = s_d.lvl & ~s_q.lvl;
endmodule // ipd_edge_sync

// ==== hw/ipd_prescaler.sv ====
// ipd_prescaler: programmable 14-bit pre-divider for reference inputs
// assumes reference inputs below half of sys_clk after sampling
//
// Contract
// - the divisor is 14 bits, low register gives 7:0, high gives 13:8.
// - the low divisor register is read/write and resets to all ones.
// - the high register is read/write, resets to 0x3F, bits 7:6 unused.
// - only inputs selected for the prescaler are divided, others pass.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module ipd_prescaler
  import ipd_pkg::*;
#(
  parameter int N_IN = 2                // number of reference inputs
) (
  input  wire logic              sys_clk,          // 25 MHz clock
  input  wire logic              rstn,             // async reset, low
  input  wire logic [9:0]        avs_address,      // byte address
  input  wire logic              avs_read,         // read request
  input  wire logic              avs_write,        // write request
  input  wire logic [31:0]       avs_writedata,    // write data
  input  wire logic [3:0]        avs_byteenable,   // byte lanes
  output logic      [31:0]       avs_readdata,     // read data
  output logic                   avs_waitrequest,  // stall
  input  wire logic [N_IN-1:0]   ref_in,           // reference pins
  output logic      [N_IN-1:0]   ref_out           // to monitors
);
  typedef struct packed {
    logic [7:0]              div_low;
    logic [IPD_HIGH_W-1:0]   div_high;
    logic [N_IN-1:0]         path_sel;
    logic [N_IN-1:0]         half_sel;
    logic [N_IN-1:0][13:0]   cnt;
    logic [N_IN-1:0]         out;
    logic                    ack;
    logic [31:0]             rdata;
  } ipd_state_t;
  ipd_state_t s_q, s_d;

  logic [N_IN-1:0] lvl;
  logic [N_IN-1:0] rise;
  logic [13:0]     divisor;
  logic            req;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_sync
      ipd_edge_sync u_sync (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .pin_in    (ref_in[g]),
        .level_out (lvl[g]),
        .rise_out  (rise[g])
      );
    end
  endgenerate

  assign divisor = {s_q.div_high, s_q.div_low};
  assign req     = avs_read | avs_write;
  // one wait cycle, answer on the second edge
  assign avs_waitrequest = req & ~s_q.ack;

  // ****************************************************************
  // bus slave and divider
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.ack = req & ~s_q.ack;
    if (avs_write && s_q.ack && avs_byteenable[0]) begin
      unique case (avs_address)
        IPD_ADDR_DIV_LOW:  s_d.div_low  = avs_writedata[7:0];
        IPD_ADDR_DIV_HIGH: s_d.div_high = avs_writedata[IPD_HIGH_W-1:0];
        IPD_ADDR_PATH_SEL: s_d.path_sel = avs_writedata[N_IN-1:0];
        default: ;
      endcase
    end
    if (avs_read && !s_q.ack) begin
      unique case (avs_address)
        IPD_ADDR_DIV_LOW:  s_d.rdata = {24'h00_0000, s_q.div_low};
        IPD_ADDR_DIV_HIGH: s_d.rdata = {26'h000_0000, s_q.div_high};
        IPD_ADDR_PATH_SEL: s_d.rdata = 32'({s_q.path_sel});
        IPD_ADDR_STATUS:   s_d.rdata = 32'({lvl, s_q.out});
        default:           s_d.rdata = IPD_UNMAPPED_RD;
      endcase
    end
    // count divisor+1 rises per output cycle
    for (int i = 0; i < N_IN; i++) begin
      if (rise[i]) begin
        if (s_q.cnt[i] >= divisor) begin
          s_d.cnt[i] = 14'h0000;
          s_d.out[i] = 1'b1;
        end else begin
          s_d.cnt[i] = s_q.cnt[i] + 14'h0001;
          if (s_q.cnt[i] == (divisor >> 1)) begin
            s_d.out[i] = 1'b0;
          end
        end
      end else if (divisor == 14'h0000 && !lvl[i]) begin
        // divide by one: follow the settled low phase, else out sticks high
        s_d.out[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.div_low  <= IPD_DIV_LOW_RST;
      s_q.div_high <= IPD_DIV_HIGH_RST[IPD_HIGH_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign ref_out      = (s_q.path_sel & s_q.out) | (~s_q.path_sel & lvl);
  assign avs_readdata = s_q.rdata;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  div_assemble_a: assert property (
    divisor[7:0] == s_q.div_low && divisor[13:8] == s_q.div_high)
    else $error("divisor not assembled from registers");
  low_write_a: assert property (
    avs_write && !avs_waitrequest && avs_byteenable[0] &&
    avs_address == IPD_ADDR_DIV_LOW |=> s_q.div_low == $past(avs_writedata[7:0]))
    else $error("low divisor write lost");
  high_read_a: assert property (
    avs_read && !avs_waitrequest && avs_address == IPD_ADDR_DIV_HIGH
    |-> avs_readdata[31:6] == 26'h000_0000)
    else $error("high register unused bits not zero");
  bypass_a: assert property (
    !s_q.path_sel[0] |-> ref_out[0] == lvl[0])
    else $error("unselected input altered");
  wrap_a: assert property (
    rise[0] && s_q.cnt[0] >= divisor |=> s_q.cnt[0] == 14'h0000 && s_q.out[0])
    else $error("counter did not wrap at divisor");
  count_a: assert property (
    rise[0] && s_q.cnt[0] < divisor |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 14'h0001)
    else $error("counter did not advance");
  wait_a: assert property (
    req && !s_q.ack |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait");

  wr_c:  cover property (avs_write && !avs_waitrequest);
  rd_c:  cover property (avs_read && !avs_waitrequest);
  out_c: cover property (s_q.path_sel[0] && $rose(s_q.out[0]));
endmodule // ipd_prescaler

// ==== tb/ipd_ref_src.sv ====
// ipd_ref_src: reference clock source feeding one prescaler input
// assumes the bench picks a half period in ns; clock stands low when off
`timescale 1ns/1ps
module ipd_ref_src (
  input  wire logic run,     // source enable
  input  int        half_ns, // half period in ns
  output logic      clk_out  // reference clock
);
  // rate held below the input limit
  // floor of 80 ns also keeps it at or below a quarter of sys_clk
  initial begin
    clk_out = 1'b0;
    forever begin
      #(half_ns < 80 ? 80 : half_ns);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule // ipd_ref_src

// ==== tb/tb_input_ref_prescale_divider.sv ====
// tb_input_ref_prescale_divider: self-checking bench for the pre-divider
// assumes ipd_pkg, ipd_prescaler and ipd_ref_src are compiled first
`timescale 1ns/1ps
module tb_input_ref_prescale_divider;
  import ipd_pkg::*;
  logic        sys_clk, rstn, avs_read, avs_write, run;
  logic [9:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  logic [1:0]  ref_in, ref_out;
  int          fail_count, comparisons, cyc, seed, dv, last0, armed;
  int          rin0, rin1, rout1;
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  ipd_prescaler #(.N_IN(2)) u_ipd_prescaler (.sys_clk(sys_clk),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ref_in(ref_in), .ref_out(ref_out));
  ipd_ref_src u_ipd_ref_src (.run(run), .half_ns(200), .clk_out(ref_in[0]));
  ipd_ref_src u_ipd_ref_src_b (.run(run), .half_ns(260),
    .clk_out(ref_in[1]));
  // ********************************************************************
  // shared tasks
  // ********************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // waitrequest sampled low ends a wait; if it never drops, only the bench cycle ceiling does
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  // unused top bits of the high register are written as ones on purpose
  task automatic set_div(input logic [13:0] d);
    logic [31:0] lo, hi;
    bus(1'b1, IPD_ADDR_DIV_LOW, {24'h0, d[7:0]}, lo);
    bus(1'b1, IPD_ADDR_DIV_HIGH, {24'h0, 2'b11, d[13:8]}, hi);
    bus(1'b0, IPD_ADDR_DIV_LOW, 32'h0, lo);
    bus(1'b0, IPD_ADDR_DIV_HIGH, 32'h0, hi);
    chk("divisor", {18'h0, hi[5:0], lo[7:0]}, {18'h0, d});
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********************************************************************
  // observers and hang guard
  // ********************************************************************
  always @(posedge ref_in[0]) rin0++;
  always @(posedge ref_in[1]) rin1++;
  always @(posedge ref_out[1]) rout1++;
  // input rises between divided output rises
  always @(posedge ref_out[0]) begin
    if (armed > 0) chk("out_spacing", rin0 - last0, dv + 1);
    armed = 1;
    last0 = rin0;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end
  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    seed = 32'h6a6ea364;
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    run = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, IPD_ADDR_DIV_LOW, 32'h0, q);
    chk("low_reset", q[7:0], IPD_DIV_LOW_RST);
    bus(1'b0, IPD_ADDR_DIV_HIGH, 32'h0, q);
    chk("high_reset", q[7:0], IPD_DIV_HIGH_RST);
    bus(1'b1, 10'h200, 32'hFFFF_FFFF, q);
    bus(1'b0, 10'h200, 32'h0, q);
    chk("unmapped", q, IPD_UNMAPPED_RD);
    set_div(IPD_DIV_MAX);
    bus(1'b1, IPD_ADDR_PATH_SEL, 32'h1, q);
    // input 1 bypassed while input 0 is divided
    for (int i = 0; i < 6; i++) begin
      dv = (i == 0) ? 0 : (i == 1) ? 256 : ($random(seed) & 32'h7);
      set_div(dv[13:0]);
      armed = 0;
      rin1 = 0;
      rout1 = 0;
      run <= 1'b1;
      repeat ((dv + 1) * 30 + 40) @(posedge sys_clk);
      run <= 1'b0;
      repeat (40) @(posedge sys_clk);
      chk("bypass_rises", rout1, rin1);
    end
    close_out();
  end
endmodule // tb_input_ref_prescale_divider
